// >>> wdtsl_pkg.sv
// wdtsl_pkg: constants and carrier types of the fused-safety watchdog.
// assumes one 100 MHz system clock and an AHB-Lite register port.
package wdtsl_pkg;

    // ==========================================================
    // register map (byte addresses, one word each)
    localparam logic [7:0] WDTSL_OFF_CTRL = 8'h00;
    localparam logic [7:0] WDTSL_OFF_RSTF = 8'h04;
    localparam logic [7:0] WDTSL_OFF_KICK = 8'h08;
    localparam logic [7:0] WDTSL_OFF_STAT = 8'h0c;
    localparam int WDTSL_MAP_BITS = 8;

    // ==========================================================
    // field positions
    localparam int WDTSL_CE_BIT = 4;
    localparam int WDTSL_WDE_BIT = 3;
    localparam int WDTSL_SEL_LSB = 0;
    localparam int WDTSL_SEL_W = 3;
    localparam int WDTSL_WATCHDOG_RESET_FLAG_BIT = 3;

    // ==========================================================
    // reset values
    localparam logic [2:0] WDTSL_SEL_RST = 3'h0;
    localparam logic [7:0] WDTSL_CTRL_RSVD = 8'h00;

    // ==========================================================
    // safety levels
    localparam logic [1:0] WDTSL_LEVEL0 = 2'h0;
    localparam logic [1:0] WDTSL_LEVEL1 = 2'h1;
    localparam logic [1:0] WDTSL_LEVEL2 = 2'h2;

    // ==========================================================
    // timing
    localparam int WDTSL_CE_WINDOW = 4;
    localparam int WDTSL_MCLK_HZ = 100_000_000;
    localparam int WDTSL_OSC_HZ = 1_000_000;
    localparam int WDTSL_OSC_DIV = WDTSL_MCLK_HZ / WDTSL_OSC_HZ;
    localparam int WDTSL_BASE_COUNT = 16_384;

    // change-enable window state
    typedef enum logic [1:0] {
        WDTSL_CE_CLOSED = 2'b01,
        WDTSL_CE_OPEN = 2'b10
    } wdtsl_ce_t;

    // register write and read carriers from the bus slave
    typedef struct packed {
        logic en;
        logic [1:0] idx;
        logic [7:0] data;
    } wdtsl_wr_t;

    typedef struct packed {
        logic hit;
        logic [1:0] idx;
    } wdtsl_rd_t;

endpackage

// >>> wdtsl_ahb.sv
// wdtsl_ahb: AHB-Lite slave front end for the watchdog registers.
// assumes single word transfers; answers with zero wait states, always OKAY.
`timescale 1ns/1ps
`default_nettype none
module wdtsl_ahb
    import wdtsl_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // register side
    output wdtsl_wr_t wr,
    output wdtsl_rd_t rd,
    input wire logic [7:0] rd_val
);

    typedef struct packed {
        logic pend;
        logic hit;
        logic [1:0] idx;
        logic [31:0] rdata;
    } wdtsl_ahb_st_t;

    wdtsl_ahb_st_t s_q, s_d;
    logic take;
    logic hit;

    // hsize is not checked: only whole words are issued to this slave
    assign take = hsel & hready & htrans[1];
    assign hit = (haddr[31:WDTSL_MAP_BITS] == '0) && (haddr[1:0] == 2'h0)
        && (haddr[WDTSL_MAP_BITS-1:4] == '0);

    assign rd = '{hit: hit, idx: haddr[3:2]};
    assign wr = '{en: s_q.pend & s_q.hit, idx: s_q.idx, data: hwdata[7:0]};
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s_q.rdata;

    always_comb begin
        s_d = s_q;
        s_d.pend = take & hwrite;
        if (take) begin
            s_d.hit = hit;
            s_d.idx = haddr[3:2];
            // read data is captured at the address phase; unmapped reads zero
            s_d.rdata = (!hwrite && hit) ? {24'h000000, rd_val} : 32'h00000000;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule
`default_nettype wire

// >>> wdtsl_count.sv
// wdtsl_count: oscillator-rate tick divider and expiry counter.
// assumes run and restart are levels/pulses on mclk; expire is one mclk cycle.
`timescale 1ns/1ps
`default_nettype none
module wdtsl_count
    import wdtsl_pkg::*;
#(
    parameter int OSC_DIV = WDTSL_OSC_DIV,
    parameter int BASE_COUNT = WDTSL_BASE_COUNT
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // control
    input wire logic run,
    input wire logic restart,
    input wire logic [2:0] sel,
    // expiry pulse
    output logic expire
);

    localparam int DW = $clog2(OSC_DIV);
    localparam int CW = $clog2(BASE_COUNT) + 8;

    if (OSC_DIV < 2 || BASE_COUNT < 2) begin : g_chk
        $error("wdtsl_count: OSC_DIV and BASE_COUNT must be at least 2");
    end

    typedef struct packed {
        logic [DW-1:0] div;
        logic [CW-1:0] cnt;
        logic expire;
    } wdtsl_cnt_st_t;

    wdtsl_cnt_st_t s_q, s_d;
    logic tick;
    logic [CW-1:0] limit;

    // the oscillator domain is modelled as a one-cycle enable on mclk
    assign tick = (s_q.div == DW'(OSC_DIV - 1));
    assign limit = CW'(BASE_COUNT) << sel;
    assign expire = s_q.expire;

    always_comb begin
        s_d = s_q;
        s_d.expire = 1'b0;
        s_d.div = tick ? '0 : s_q.div + DW'(1);
        if (!run || restart) begin
            s_d.cnt = '0;
        end else if (tick) begin
            if (s_q.cnt >= limit - CW'(1)) begin
                s_d.cnt = '0;
                s_d.expire = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + CW'(1);
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule
`default_nettype wire

// >>> wdtsl_top.sv
// wdtsl_top: watchdog with fuse-selected safety levels and timed change window.
// assumes fuses are static, por pulses only on power-up, and the chip reset
// controller turns reset_pulse into rst_n.
//
// Function
// - fuses give level 0, 1 or 2; always-on fuse forces level 2
// - levels 0 and 1 start disabled; level 2 starts enabled
// - writing one to enable always turns the watchdog on
// - control bits 7..5 read as zero
// - writing zero to enable disables only while change-enable is already set
// - change-enable clears itself four cycles after being written one
// - at levels 1 and 2 select writes land only inside the open window
// - bit 3 is enable: one enables, an allowed zero disables
// - level 2 never disables the watchdog
// - select 0..7 gives 16384 doubling up to 2097152 oscillator cycles
// - at level 0 select may be written at any time
// - at level 2 enable reads one and the watchdog always runs
// - counter advances at the nominal 1 MHz oscillator rate
// - counter restarts on restart command, while disabled, and on chip reset
// - expiry without restart gives a one-clock reset pulse
// - watchdog reset sets the flag; cleared by power-on or writing zero
//
// The register offsets and the AHB-Lite register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module wdtsl_top
    import wdtsl_pkg::*;
#(
    parameter int OSC_DIV = WDTSL_OSC_DIV,
    parameter int BASE_COUNT = WDTSL_BASE_COUNT
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic por,
    // fuses, high when programmed
    input wire logic compatibility_fuse,
    input wire logic always_on_fuse,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // to chip reset controller and status
    output logic reset_pulse,
    output logic watchdog_running,
    output logic [1:0] safety_level
);

    // ==========================================================
    // state
    typedef struct packed {
        logic fused;
        logic [1:0] level;
        logic watchdog_enable_bit;
        wdtsl_ce_t ce;
        logic [2:0] ce_cnt;
        logic [2:0] sel;
        logic kick;
    } wdtsl_st_t;

    wdtsl_st_t s_q, s_d;
    logic watchdog_reset_flag_q, watchdog_reset_flag_d;
    wdtsl_wr_t wr;
    wdtsl_rd_t rd;
    logic [7:0] rd_val;
    logic expire;
    logic ce_open;
    logic wr_ctrl;
    logic wr_rstf;
    logic wr_kick;
    logic [7:0] ctrl_view;
    logic [1:0] fuse_level;

    // ==========================================================
    // bus front end
    wdtsl_ahb u_ahb (
        .mclk(mclk),
        .rst_n(rst_n),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .wr(wr),
        .rd(rd),
        .rd_val(rd_val)
    );

    // ==========================================================
    // expiry counter
    wdtsl_count #(
        .OSC_DIV(OSC_DIV),
        .BASE_COUNT(BASE_COUNT)
    ) u_count (
        .mclk(mclk),
        .rst_n(rst_n),
        .run(s_q.watchdog_enable_bit & s_q.fused),
        .restart(s_q.kick),
        .sel(s_q.sel),
        .expire(expire)
    );

    // ==========================================================
    // fuse decode
    always_comb begin
        if (always_on_fuse) begin
            fuse_level = WDTSL_LEVEL2;
        end else if (compatibility_fuse) begin
            fuse_level = WDTSL_LEVEL0;
        end else begin
            fuse_level = WDTSL_LEVEL1;
        end
    end

    // ==========================================================
    // register decode
    assign ce_open = (s_q.ce == WDTSL_CE_OPEN);
    assign wr_ctrl = wr.en && ({4'h0, wr.idx, 2'h0} == WDTSL_OFF_CTRL);
    assign wr_rstf = wr.en && ({4'h0, wr.idx, 2'h0} == WDTSL_OFF_RSTF);
    assign wr_kick = wr.en && ({4'h0, wr.idx, 2'h0} == WDTSL_OFF_KICK);

    // level 2 shows enable as one regardless of stored state
    always_comb begin
        ctrl_view = WDTSL_CTRL_RSVD;
        ctrl_view[WDTSL_CE_BIT] = ce_open;
        ctrl_view[WDTSL_WDE_BIT] = s_q.watchdog_enable_bit | (s_q.level == WDTSL_LEVEL2);
        ctrl_view[WDTSL_SEL_LSB +: WDTSL_SEL_W] = s_q.sel;
    end

    always_comb begin
        rd_val = 8'h00;
        if (rd.hit) begin
            case ({4'h0, rd.idx, 2'h0})
                WDTSL_OFF_CTRL: rd_val = ctrl_view;
                WDTSL_OFF_RSTF: rd_val[WDTSL_WATCHDOG_RESET_FLAG_BIT] = watchdog_reset_flag_q;
                WDTSL_OFF_STAT: rd_val = {5'h00, s_q.watchdog_enable_bit, s_q.level};
                default: rd_val = 8'h00;
            endcase
        end
    end

    // ==========================================================
    // control register behaviour
    always_comb begin
        s_d = s_q;
        s_d.kick = wr_kick;
        if (!s_q.fused) begin
            // fuses are caught once, in the first cycle after reset release
            s_d.fused = 1'b1;
            s_d.level = fuse_level;
            s_d.watchdog_enable_bit = (fuse_level == WDTSL_LEVEL2);
        end else begin
            // change-enable window countdown
            case (s_q.ce)
                WDTSL_CE_OPEN: begin
                    if (s_q.ce_cnt == 3'h1) begin
                        s_d.ce = WDTSL_CE_CLOSED;
                        s_d.ce_cnt = 3'h0;
                    end else begin
                        s_d.ce_cnt = s_q.ce_cnt - 3'h1;
                    end
                end
                WDTSL_CE_CLOSED: s_d.ce_cnt = 3'h0;
                default: begin
                    s_d.ce = WDTSL_CE_CLOSED;
                    s_d.ce_cnt = 3'h0;
                end
            endcase
            if (wr_ctrl) begin
                // a fresh one restarts the window from its full length
                if (wr.data[WDTSL_CE_BIT]) begin
                    s_d.ce = WDTSL_CE_OPEN;
                    s_d.ce_cnt = 3'(WDTSL_CE_WINDOW);
                end
                if (wr.data[WDTSL_WDE_BIT]) begin
                    s_d.watchdog_enable_bit = 1'b1;
                end else if (ce_open && s_q.level != WDTSL_LEVEL2) begin
                    s_d.watchdog_enable_bit = 1'b0;
                end
                if (s_q.level == WDTSL_LEVEL0 || ce_open) begin
                    s_d.sel = wr.data[WDTSL_SEL_LSB +: WDTSL_SEL_W];
                end
            end
            if (s_q.level == WDTSL_LEVEL2) begin
                s_d.watchdog_enable_bit = 1'b1;
            end
        end
    end

    // ==========================================================
    // watchdog reset flag: survives chip reset, set beats a write clear, por beats set
    always_comb begin
        watchdog_reset_flag_d = watchdog_reset_flag_q;
        if (wr_rstf && !wr.data[WDTSL_WATCHDOG_RESET_FLAG_BIT]) begin
            watchdog_reset_flag_d = 1'b0;
        end
        if (expire) begin
            watchdog_reset_flag_d = 1'b1;
        end
        if (por) begin
            watchdog_reset_flag_d = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s_q <= '{fused: 1'b0, level: WDTSL_LEVEL1, watchdog_enable_bit: 1'b0,
                     ce: WDTSL_CE_CLOSED, ce_cnt: 3'h0, sel: WDTSL_SEL_RST,
                     kick: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // the flag must outlive the reset it reports, so rst_n never clears it; only por or a zero write does
    always_ff @(posedge mclk) begin
        watchdog_reset_flag_q <= watchdog_reset_flag_d;
    end

    // ==========================================================
    // outputs
    assign reset_pulse = expire;
    assign watchdog_running = s_q.watchdog_enable_bit;
    assign safety_level = s_q.level;

endmodule
`default_nettype wire

// >>> wdtsl_top_asserts.sv
// wdtsl_top_asserts: port-level checks of the fused-safety watchdog.
// assumes a single-transfer ahb master and fuses that change only in reset.
`timescale 1ns/1ps
`default_nettype none
module wdtsl_top_asserts
    import wdtsl_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // fuses and bus inputs
    input wire logic compatibility_fuse,
    input wire logic always_on_fuse,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    // design outputs
    input wire logic [31:0] hrdata,
    input wire logic reset_pulse,
    input wire logic watchdog_running,
    input wire logic [1:0] safety_level
);
    // ==========================================================
    // helpers: control write in data phase, cycles left in the change window
    logic wr_q;
    logic [2:0] ce_q;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wr_q <= 1'b0;
            ce_q <= 3'h0;
        end else begin
            wr_q <= hsel && hready && htrans[1] && hwrite && haddr == {24'h0, WDTSL_OFF_CTRL};
            if (wr_q && hwdata[WDTSL_CE_BIT]) begin
                ce_q <= 3'h4;
            end else if (ce_q != 3'h0) begin
                ce_q <= ce_q - 3'h1;
            end
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // ==========================================================
    // properties
    property p_level;
        rst_n && $past(rst_n) |-> safety_level == (always_on_fuse ? WDTSL_LEVEL2 :
            (compatibility_fuse ? WDTSL_LEVEL0 : WDTSL_LEVEL1));
    endproperty
    a_level: assert property (p_level) else $error("level does not follow fuses");
    property p_init;
        $rose(rst_n) |=> watchdog_running == always_on_fuse;
    endproperty
    a_init: assert property (p_init) else $error("wrong enable after reset");
    property p_enable;
        wr_q && hwdata[WDTSL_WDE_BIT] |=> watchdog_running;
    endproperty
    a_enable: assert property (p_enable) else $error("enable write ignored");
    property p_rsvd;
        hrdata[7:5] == 3'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");
    property p_refuse;
        wr_q && !hwdata[WDTSL_WDE_BIT] && ce_q == 3'h0 |=>
            watchdog_running == $past(watchdog_running);
    endproperty
    a_refuse: assert property (p_refuse) else $error("disabled without window");
    property p_disable;
        wr_q && !hwdata[WDTSL_WDE_BIT] && ce_q >= 3'h2 && safety_level != WDTSL_LEVEL2
            |=> !watchdog_running;
    endproperty
    a_disable: assert property (p_disable) else $error("disable in window failed");
    property p_lvl2;
        safety_level == WDTSL_LEVEL2 |-> watchdog_running;
    endproperty
    a_lvl2: assert property (p_lvl2) else $error("level 2 not running");
    property p_pulse;
        reset_pulse |=> !reset_pulse;
    endproperty
    a_pulse: assert property (p_pulse) else $error("reset pulse too long");

    c_pulse: cover property (reset_pulse);
    c_disable: cover property (wr_q && !hwdata[WDTSL_WDE_BIT] && ce_q >= 3'h2);
    c_lvl2: cover property (safety_level == WDTSL_LEVEL2 && watchdog_running);
endmodule

bind wdtsl_top wdtsl_top_asserts u_asserts (.mclk, .rst_n, .compatibility_fuse,
    .always_on_fuse, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata,
    .reset_pulse, .watchdog_running, .safety_level);
`default_nettype wire

// >>> wdtsl_rst_ctl.sv
// wdtsl_rst_ctl: chip reset controller model fed by the watchdog pulse.
// assumes the bench ands chip_rst_n into the block's rst_n.
`timescale 1ns/1ps
`default_nettype none
module wdtsl_rst_ctl (
    // clock and control
    input wire logic mclk,
    input wire logic arm,
    // from watchdog
    input wire logic reset_pulse,
    // to chip
    output logic chip_rst_n,
    output logic [7:0] pulses
);
    // ==========================================================
    // every high cycle counts, so a stretched pulse shows twice
    logic [1:0] hold_q = 2'h0;
    logic [7:0] cnt_q = 8'h0;
    always_ff @(posedge mclk) begin
        if (reset_pulse) begin
            cnt_q <= cnt_q + 8'h1;
        end
        if (reset_pulse && arm) begin
            hold_q <= 2'h3;
        end else if (hold_q != 2'h0) begin
            hold_q <= hold_q - 2'h1;
        end
    end
    assign chip_rst_n = hold_q == 2'h0;
    assign pulses = cnt_q;
endmodule
`default_nettype wire

// >>> test_watchdog_timer_safety_levels.sv
// test_watchdog_timer_safety_levels: register sequences at all fuse levels.
// assumes shortened counts: oscillator divide 2, base count 8.
`timescale 1ns/1ps
`default_nettype none
module test_watchdog_timer_safety_levels
    import wdtsl_pkg::*;
;
    localparam int DIV = 2;
    localparam int BASE = 8;
    localparam logic [3:0] CF_TAB = 4'b1001;
    localparam logic [3:0] AO_TAB = 4'b1100;
    logic mclk, tb_rst_n, rst_n, chip_rst_n, por, arm, ok, e;
    logic compatibility_fuse, always_on_fuse, hsel, hwrite, hreadyout, hresp;
    logic reset_pulse, watchdog_running;
    logic [1:0] htrans, safety_level, lv;
    logic [2:0] s;
    logic [7:0] pulses, p0;
    logic [31:0] haddr, hwdata, hrdata;
    int errors, num_checks, n, expc;
    assign rst_n = tb_rst_n & chip_rst_n;

    wdtsl_top #(.OSC_DIV(DIV), .BASE_COUNT(BASE)) dut (.mclk(mclk), .rst_n(rst_n),
        .por(por), .compatibility_fuse(compatibility_fuse), .always_on_fuse(always_on_fuse),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .reset_pulse(reset_pulse), .watchdog_running(watchdog_running),
        .safety_level(safety_level));
    wdtsl_rst_ctl u_rstc (.mclk(mclk), .arm(arm), .reset_pulse(reset_pulse),
        .chip_rst_n(chip_rst_n), .pulses(pulses));

    // ==========================================================
    // tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        num_checks++;
        if (got !== want) begin
            errors++;
            $display("Error at %0t: got %h want %h", $time, got, want);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge mclk);
    endtask
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
            output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(a, 1'b1, d, q);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] want);
        logic [31:0] q;
        bus(a, 1'b0, 32'h0, q);
        chk(q, want);
    endtask
    task automatic do_reset(input logic c, input logic a);
        tb_rst_n <= 1'b0;
        por <= 1'b1;
        compatibility_fuse <= c;
        always_on_fuse <= a;
        cyc(3);
        tb_rst_n <= 1'b1;
        por <= 1'b0;
        cyc(2);
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ==========================================================
    // clock, watchdog, tests
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        repeat (30000) @(posedge mclk);
        errors++;
        $display("Error at %0t: timeout", $time);
        close_out();
    end
    initial begin
        {tb_rst_n, por, arm, hsel, hwrite, htrans, haddr, hwdata} = '0;
        {compatibility_fuse, always_on_fuse, errors, num_checks} = '0;
        for (int i = 0; i < 4; i++) begin
            lv = AO_TAB[i] ? WDTSL_LEVEL2 : (CF_TAB[i] ? WDTSL_LEVEL0 : WDTSL_LEVEL1);
            e = lv == WDTSL_LEVEL2;
            s = (lv == WDTSL_LEVEL0) ? 3'h5 : 3'h0;
            do_reset(CF_TAB[i], AO_TAB[i]);
            rdc(WDTSL_OFF_STAT, {29'h0, e, lv});
            rdc(WDTSL_OFF_CTRL, {28'h0, e, 3'h0});
            wr(WDTSL_OFF_CTRL, 32'h0d);
            rdc(WDTSL_OFF_CTRL, {28'h1, s});
            // keep select at s: level 0 loads select on every write
            wr(WDTSL_OFF_CTRL, {29'h0, s});
            rdc(WDTSL_OFF_CTRL, {28'h1, s});
            wr(WDTSL_OFF_CTRL, {28'h3, s});
            rdc(WDTSL_OFF_CTRL, {28'h3, s});
            cyc(6);
            rdc(WDTSL_OFF_CTRL, {28'h1, s});
            wr(WDTSL_OFF_CTRL, {29'h0, s});
            rdc(WDTSL_OFF_CTRL, {28'h1, s});
            wr(WDTSL_OFF_CTRL, 32'h18);
            wr(WDTSL_OFF_CTRL, 32'h0b);
            // let the window close so change-enable reads back zero
            cyc(4);
            rdc(WDTSL_OFF_CTRL, 32'h0b);
            wr(WDTSL_OFF_CTRL, 32'h18);
            wr(WDTSL_OFF_CTRL, 32'h02);
            cyc(4);
            rdc(WDTSL_OFF_CTRL, {28'h0, e, 3'h2});
            rdc(8'h40, 32'h0);
        end
        $display("test levels done");
        arm <= 1'b1;
        do_reset(1'b1, 1'b0);
        p0 = pulses;
        for (int k = 0; k < 8; k++) begin
            wr(WDTSL_OFF_CTRL, {29'h1, k[2:0]});
            n = 0;
            while (reset_pulse !== 1'b1) begin
                @(posedge mclk);
                n++;
            end
            expc = (BASE << k) * DIV;
            ok = n > expc - 2 * DIV - 3 && n < expc + 2 * DIV + 3;
            chk({31'h0, ok}, 32'h1);
            cyc(8);
        end
        chk({24'h0, pulses - p0}, 32'h8);
        rdc(WDTSL_OFF_STAT, 32'h0);
        rdc(WDTSL_OFF_RSTF, 32'h08);
        wr(WDTSL_OFF_RSTF, 32'h0);
        rdc(WDTSL_OFF_RSTF, 32'h0);
        $display("test expiry done");
        wr(WDTSL_OFF_CTRL, 32'h08);
        repeat (10) begin
            wr(WDTSL_OFF_KICK, 32'h1);
            cyc(6);
        end
        wr(WDTSL_OFF_CTRL, 32'h18);
        wr(WDTSL_OFF_CTRL, 32'h00);
        cyc(100);
        chk({24'h0, pulses - p0}, 32'h8);
        $display("test restart done");
        close_out();
    end
endmodule
`default_nettype wire
